// ---- rtl/aod_pkg.sv ----
/*
 * Shared constants for the operand address decoder: mode codes,
 * displacement length prefixes, operand kinds and decoder states.
 * Assumes nothing of its surroundings.
 */
package aod_pkg;
  // operand mode codes
  localparam logic [4:0] MODE_FRAME_REL = 5'h10;
  localparam logic [4:0] MODE_STACK_REL = 5'h11;
  localparam logic [4:0] MODE_STATIC_REL = 5'h12;
  localparam logic [4:0] MODE_RESERVED = 5'h13;
  localparam logic [4:0] MODE_IMMEDIATE = 5'h14;
  localparam logic [4:0] MODE_ABSOLUTE = 5'h15;
  localparam logic [4:0] MODE_EXTERNAL = 5'h16;
  localparam logic [4:0] MODE_TOP_OF_STACK = 5'h17;
  localparam logic [4:0] MODE_FRAME_MEM = 5'h18;
  localparam logic [4:0] MODE_STACK_MEM = 5'h19;
  localparam logic [4:0] MODE_STATIC_MEM = 5'h1a;
  localparam logic [4:0] MODE_PROGRAM_MEM = 5'h1b;
  // top three bits of the scaled index codes
  localparam logic [2:0] MODE_SCALED_TOP = 3'h7;
  // top two bits of register and register relative codes
  localparam logic [1:0] MODE_REGISTER_TOP = 2'h0;
  localparam logic [1:0] MODE_REG_REL_TOP = 2'h1;
  // displacement length prefix: 0 one byte, 10 two, 11 four
  localparam logic [1:0] DISP_PREFIX_TWO = 2'h2;
  localparam logic [2:0] DISP_BYTES_ONE = 3'h1;
  localparam logic [2:0] DISP_BYTES_TWO = 3'h2;
  localparam logic [2:0] DISP_BYTES_FOUR = 3'h4;
  // index byte fields
  localparam int INDEX_MODE_LSB = 3;
  // operand kinds reported downstream
  localparam logic [1:0] KIND_REGISTER = 2'h0;
  localparam logic [1:0] KIND_MEMORY = 2'h1;
  localparam logic [1:0] KIND_IMMEDIATE = 2'h2;
  // decoder states, one-hot
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_INDEX = 8'h02,
    ST_PREP = 8'h04,
    ST_FIELD1 = 8'h08,
    ST_FIELD2 = 8'h10,
    ST_POINTER = 8'h20,
    ST_EMIT = 8'h40,
    ST_IMPLIED = 8'h80
  } aod_state_t;
endpackage : aod_pkg

// ---- rtl/aod_field_assemble.sv ----
/*
 * Collects one displacement or immediate field from the byte stream,
 * most significant byte first; a displacement returns sign extended, an immediate as collected.
 * Assumes bytes arrive on a valid/ready handshake in the clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module aod_field_assemble (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic i_is_imm,
  input wire logic [2:0] i_imm_len,
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  output logic o_byte_ready,
  output logic o_done,
  output logic [31:0] o_value
);
  typedef struct packed {
    logic busy;
    logic first;
    logic imm;
    logic [2:0] left;
    logic [2:0] total;
    logic [31:0] acc;
    logic done;
    logic [31:0] value;
  } aod_fa_t;
  aod_fa_t s;
  aod_fa_t next_s;
  logic [31:0] acc_new;
  logic [2:0] tot;
  logic [2:0] left_now;

  assign o_byte_ready = s.busy;
  assign o_done = s.done;
  assign o_value = s.value;

  // length from the prefix for a displacement, from the opcode otherwise
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    acc_new = {s.acc[23:0], i_byte};
    tot = s.total;
    if (s.first) begin
      if (s.imm) begin
        tot = i_imm_len;
      end else if (!i_byte[7]) begin
        tot = aod_pkg::DISP_BYTES_ONE;
      end else if (i_byte[7:6] == aod_pkg::DISP_PREFIX_TWO) begin
        tot = aod_pkg::DISP_BYTES_TWO;
      end else begin
        tot = aod_pkg::DISP_BYTES_FOUR;
      end
    end
    left_now = s.first ? tot : s.left;
    if (i_start) begin
      next_s.busy = 1'b1;
      next_s.first = 1'b1;
      next_s.imm = i_is_imm;
      next_s.acc = 32'h0;
    end else if (s.busy && i_byte_valid) begin
      next_s.first = 1'b0;
      next_s.total = tot;
      next_s.acc = acc_new;
      next_s.left = left_now - 3'h1;
      if (left_now == 3'h1) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
        // displacement prefix bits dropped, the rest sign extended; immediates kept whole
        if (s.imm) begin
          next_s.value = acc_new;
        end else if (tot == aod_pkg::DISP_BYTES_ONE) begin
          next_s.value = {{25{acc_new[6]}}, acc_new[6:0]};
        end else if (tot == aod_pkg::DISP_BYTES_TWO) begin
          next_s.value = {{18{acc_new[13]}}, acc_new[13:0]};
        end else begin
          next_s.value = {{2{acc_new[29]}}, acc_new[29:0]};
        end
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule // aod_field_assemble
`default_nettype wire

// ---- rtl/aod_base_select.sv ----
/*
 * Picks the base register value that a mode code adds its
 * displacement to. Assumes register inputs are stable while used.
 */
`timescale 1ns/1ps
`default_nettype none
module aod_base_select (
  input wire logic [4:0] i_mode,
  input wire logic [255:0] i_gpr,
  input wire logic [31:0] i_frame_pointer,
  input wire logic [31:0] i_stack_pointer_zero,
  input wire logic [31:0] i_stack_pointer_one,
  input wire logic [31:0] i_static_base_pointer,
  input wire logic [31:0] i_program_counter,
  input wire logic i_stack_select,
  output logic [31:0] o_base,
  output logic [31:0] o_current_stack_pointer
);
  // stack select flag chooses the live stack pointer
  assign o_current_stack_pointer = i_stack_select ?
    i_stack_pointer_one : i_stack_pointer_zero;

  always_comb begin
    o_base = 32'h0;
    if (i_mode[4] == 1'b0) begin
      o_base = i_gpr[i_mode[2:0]*32 +: 32];
    end else begin
      case (i_mode)
        aod_pkg::MODE_FRAME_REL, aod_pkg::MODE_FRAME_MEM: begin
          o_base = i_frame_pointer;
        end
        aod_pkg::MODE_STACK_REL, aod_pkg::MODE_STACK_MEM: begin
          o_base = o_current_stack_pointer;
        end
        aod_pkg::MODE_STATIC_REL, aod_pkg::MODE_STATIC_MEM: begin
          o_base = i_static_base_pointer;
        end
        aod_pkg::MODE_PROGRAM_MEM: begin
          o_base = i_program_counter;
        end
        default: begin
          o_base = 32'h0;
        end
      endcase
    end
  end
endmodule // aod_base_select
`default_nettype wire

// ---- rtl/aod_decoder.sv ----
/*
 * Operand address decoder: reads index bytes, displacements and
 * immediates behind a basic instruction and forms effective addresses.
 * Assumes the opcode decoder hands over both mode fields with a start
 * pulse, and a memory unit answers pointer reads with an ack.
 */
`timescale 1ns/1ps
`default_nettype none
module aod_decoder (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic [4:0] i_gen_a,
  input wire logic [4:0] i_gen_b,
  input wire logic i_two_operands,
  input wire logic i_write_a,
  input wire logic i_write_b,
  input wire logic [2:0] i_operand_len,
  input wire logic [1:0] i_implied_count,
  input wire logic [1:0] i_implied_is_disp,
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  output logic o_byte_ready,
  input wire logic [255:0] i_gpr,
  input wire logic [31:0] i_frame_pointer,
  input wire logic [31:0] i_stack_pointer_zero,
  input wire logic [31:0] i_stack_pointer_one,
  input wire logic [31:0] i_static_base_pointer,
  input wire logic [31:0] i_program_counter,
  input wire logic [31:0] i_link_table_base,
  input wire logic i_stack_select,
  output logic o_mem_req,
  output logic [31:0] o_mem_addr,
  input wire logic i_mem_ack,
  input wire logic [31:0] i_mem_data,
  output logic o_op_valid,
  output logic o_op_index,
  output logic [1:0] o_op_kind,
  output logic [2:0] o_op_register,
  output logic [31:0] o_op_address,
  output logic [31:0] o_op_immediate,
  output logic o_sp_update,
  output logic o_sp_select,
  output logic [31:0] o_sp_value,
  output logic o_implied_valid,
  output logic o_implied_is_disp,
  output logic [31:0] o_implied_value,
  output logic o_trap_undefined,
  output logic o_done,
  output logic o_busy
);
  typedef struct packed {
    aod_pkg::aod_state_t st;
    logic op;
    logic [4:0] gen_a;
    logic [4:0] gen_b;
    logic two;
    logic wr_a;
    logic wr_b;
    logic [2:0] len;
    logic [1:0] impl_cnt;
    logic [1:0] impl_disp;
    logic [7:0] idx_a;
    logic [7:0] idx_b;
    logic [31:0] d1;
    logic [31:0] d2;
    logic [31:0] ptr;
    logic mem_req;
    logic [31:0] mem_addr;
    logic f_start;
    logic f_imm;
    logic op_valid;
    logic op_index;
    logic [1:0] kind;
    logic [2:0] reg_sel;
    logic [31:0] ea;
    logic [31:0] imm;
    logic sp_update;
    logic sp_select;
    logic [31:0] sp_value;
    logic impl_valid;
    logic impl_is_disp;
    logic [31:0] impl_value;
    logic trap;
    logic done;
  } aod_dec_t;
  aod_dec_t s;
  aod_dec_t next_s;

  logic [4:0] cur_gen;
  logic [7:0] cur_idx;
  logic cur_wr;
  logic scaled;
  logic [4:0] mode;
  logic mem_rel;
  logic is_tos;
  logic need_index;
  logic [31:0] base;
  logic [31:0] cur_sp;
  logic [31:0] len_ext;
  logic [31:0] idx_value;
  logic [31:0] idx_scaled;
  logic [31:0] ptr_addr;
  logic [31:0] core_ea;
  logic f_ready;
  logic f_done;
  logic [31:0] f_value;

  // the current operand's mode, seen through its index byte if scaled
  assign cur_gen = s.op ? s.gen_b : s.gen_a;
  assign cur_idx = s.op ? s.idx_b : s.idx_a;
  assign cur_wr = s.op ? s.wr_b : s.wr_a;
  assign scaled = cur_gen[4:2] == aod_pkg::MODE_SCALED_TOP;
  assign mode = scaled ?
    cur_idx[7:aod_pkg::INDEX_MODE_LSB] : cur_gen;
  assign mem_rel = (mode == aod_pkg::MODE_FRAME_REL) ||
    (mode == aod_pkg::MODE_STACK_REL) ||
    (mode == aod_pkg::MODE_STATIC_REL) ||
    (mode == aod_pkg::MODE_EXTERNAL);
  assign is_tos = mode == aod_pkg::MODE_TOP_OF_STACK;
  assign need_index = scaled && (!s.op || s.two);
  assign len_ext = {29'h0, s.len};

  aod_base_select u_base (
    .i_mode(mode),
    .i_gpr(i_gpr),
    .i_frame_pointer(i_frame_pointer),
    .i_stack_pointer_zero(i_stack_pointer_zero),
    .i_stack_pointer_one(i_stack_pointer_one),
    .i_static_base_pointer(i_static_base_pointer),
    .i_program_counter(i_program_counter),
    .i_stack_select(i_stack_select),
    .o_base(base),
    .o_current_stack_pointer(cur_sp)
  );

  // scale factor 1, 2, 4 or 8 comes from the low two mode bits
  assign idx_value = i_gpr[cur_idx[2:0]*32 +: 32];
  assign idx_scaled = scaled ? (idx_value << cur_gen[1:0]) : 32'h0;

  // link table entries are four bytes each
  assign ptr_addr = (mode == aod_pkg::MODE_EXTERNAL) ?
    (i_link_table_base + {s.d1[29:0], 2'h0}) :
    (base + s.d1);

  // effective address before indexing
  always_comb begin
    if (mem_rel) begin
      core_ea = s.ptr + s.d2;
    end else if (mode == aod_pkg::MODE_ABSOLUTE) begin
      core_ea = s.d1;
    end else if (is_tos) begin
      core_ea = cur_wr ? (cur_sp - len_ext) : cur_sp;
    end else begin
      core_ea = base + s.d1;
    end
  end

  aod_field_assemble u_field (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_start(s.f_start),
    .i_is_imm(s.f_imm),
    .i_imm_len(s.len),
    .i_byte_valid(i_byte_valid && (s.st != aod_pkg::ST_INDEX)),
    .i_byte(i_byte),
    .o_byte_ready(f_ready),
    .o_done(f_done),
    .o_value(f_value)
  );

  // index bytes are taken here, every other byte by the assembler
  assign o_byte_ready = (s.st == aod_pkg::ST_INDEX) ? need_index : f_ready;

  // sequencing; pulses fall back to zero each cycle
  always_comb begin
    next_s = s;
    next_s.f_start = 1'b0;
    next_s.op_valid = 1'b0;
    next_s.sp_update = 1'b0;
    next_s.impl_valid = 1'b0;
    next_s.trap = 1'b0;
    next_s.done = 1'b0;
    case (s.st)
      aod_pkg::ST_IDLE: begin
        if (i_start) begin
          next_s.gen_a = i_gen_a;
          next_s.gen_b = i_gen_b;
          next_s.two = i_two_operands;
          next_s.wr_a = i_write_a;
          next_s.wr_b = i_write_b;
          next_s.len = i_operand_len;
          next_s.impl_cnt = i_implied_count;
          next_s.impl_disp = i_implied_is_disp;
          next_s.op = 1'b0;
          next_s.st = aod_pkg::ST_INDEX;
        end
      end
      aod_pkg::ST_INDEX: begin
        // both index bytes come before any displacement
        if (!need_index || i_byte_valid) begin
          if (need_index && !s.op) begin
            next_s.idx_a = i_byte;
          end
          if (need_index && s.op) begin
            next_s.idx_b = i_byte;
          end
          if (!s.op && s.two) begin
            next_s.op = 1'b1;
          end else begin
            next_s.op = 1'b0;
            next_s.st = aod_pkg::ST_PREP;
          end
        end
      end
      aod_pkg::ST_PREP: begin
        next_s.d1 = 32'h0;
        next_s.d2 = 32'h0;
        if ((mode == aod_pkg::MODE_RESERVED) ||
            (scaled && (mode == aod_pkg::MODE_IMMEDIATE)) ||
            (scaled && (mode[4:2] == aod_pkg::MODE_SCALED_TOP)) ||
            (cur_wr && (mode == aod_pkg::MODE_IMMEDIATE))) begin
          // no address is produced; the instruction is abandoned
          next_s.trap = 1'b1;
          next_s.st = aod_pkg::ST_IDLE;
        end else if (mode[4:3] == aod_pkg::MODE_REGISTER_TOP || is_tos) begin
          next_s.st = aod_pkg::ST_EMIT;
        end else begin
          next_s.f_start = 1'b1;
          next_s.f_imm = mode == aod_pkg::MODE_IMMEDIATE;
          next_s.st = aod_pkg::ST_FIELD1;
        end
      end
      aod_pkg::ST_FIELD1: begin
        if (f_done) begin
          next_s.d1 = f_value;
          if (mem_rel) begin
            next_s.f_start = 1'b1;
            next_s.f_imm = 1'b0;
            next_s.st = aod_pkg::ST_FIELD2;
          end else begin
            next_s.st = aod_pkg::ST_EMIT;
          end
        end
      end
      aod_pkg::ST_FIELD2: begin
        if (f_done) begin
          next_s.d2 = f_value;
          next_s.mem_req = 1'b1;
          next_s.mem_addr = ptr_addr;
          next_s.st = aod_pkg::ST_POINTER;
        end
      end
      aod_pkg::ST_POINTER: begin
        // request holds until the memory unit answers
        if (i_mem_ack) begin
          next_s.mem_req = 1'b0;
          next_s.ptr = i_mem_data;
          next_s.st = aod_pkg::ST_EMIT;
        end
      end
      aod_pkg::ST_EMIT: begin
        next_s.op_valid = 1'b1;
        next_s.op_index = s.op;
        next_s.reg_sel = mode[2:0];
        next_s.imm = s.d1;
        next_s.ea = core_ea + idx_scaled;
        if (mode == aod_pkg::MODE_IMMEDIATE) begin
          next_s.kind = aod_pkg::KIND_IMMEDIATE;
        end else if (mode[4:3] == aod_pkg::MODE_REGISTER_TOP && !scaled) begin
          next_s.kind = aod_pkg::KIND_REGISTER;
        end else begin
          next_s.kind = aod_pkg::KIND_MEMORY;
        end
        if (is_tos) begin
          // push pre-decrements, pop post-increments
          next_s.sp_update = 1'b1;
          next_s.sp_select = i_stack_select;
          next_s.sp_value = cur_wr ?
            (cur_sp - len_ext) : (cur_sp + len_ext);
        end
        if (!s.op && s.two) begin
          next_s.op = 1'b1;
          next_s.st = aod_pkg::ST_PREP;
        end else begin
          next_s.st = aod_pkg::ST_IMPLIED;
        end
      end
      aod_pkg::ST_IMPLIED: begin
        // one implied field at a time, low bit first in operand order
        if (!s.f_start && f_done) begin
          next_s.impl_valid = 1'b1;
          next_s.impl_is_disp = s.impl_disp[0];
          next_s.impl_value = f_value;
          next_s.impl_disp = {1'b0, s.impl_disp[1]};
          next_s.impl_cnt = s.impl_cnt - 2'h1;
        end else if (!s.f_start && !f_ready) begin
          if (s.impl_cnt == 2'h0) begin
            next_s.done = 1'b1;
            next_s.st = aod_pkg::ST_IDLE;
          end else begin
            next_s.f_start = 1'b1;
            next_s.f_imm = !s.impl_disp[0];
          end
        end
      end
      default: begin
        next_s.st = aod_pkg::ST_IDLE;
      end
    endcase
  end

  // single state register; asynchronous reset to constants only
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
      s.st <= aod_pkg::ST_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign o_mem_req = s.mem_req;
  assign o_mem_addr = s.mem_addr;
  assign o_op_valid = s.op_valid;
  assign o_op_index = s.op_index;
  assign o_op_kind = s.kind;
  assign o_op_register = s.reg_sel;
  assign o_op_address = s.ea;
  assign o_op_immediate = s.imm;
  assign o_sp_update = s.sp_update;
  assign o_sp_select = s.sp_select;
  assign o_sp_value = s.sp_value;
  assign o_implied_valid = s.impl_valid;
  assign o_implied_is_disp = s.impl_is_disp;
  assign o_implied_value = s.impl_value;
  assign o_trap_undefined = s.trap;
  assign o_done = s.done;
  assign o_busy = s.st != aod_pkg::ST_IDLE;
endmodule // aod_decoder
`default_nettype wire

// ---- verification/aod_mem_model.sv ----
/* model of the memory access unit: answers pointer reads.
   Assumes requests hold until the acknowledge edge. */
`timescale 1ns/1ps
`default_nettype none
module aod_mem_model (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_req,
  input wire logic [31:0] i_addr,
  input wire logic i_slow,
  output logic o_ack,
  output logic [31:0] o_data
);
  logic [2:0] wait_cnt;
  // pointer is the address with a pattern folded in; stale data toggles
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_cnt <= 3'h0;
      o_ack <= 1'b0;
      o_data <= 32'h0;
    end else if (i_req && !o_ack && wait_cnt >= (i_slow ? 3'h4 : 3'h0)) begin
      o_ack <= 1'b1;
      o_data <= i_addr ^ 32'h5a5a_0000;
      wait_cnt <= 3'h0;
    end else begin
      o_ack <= 1'b0;
      o_data <= ~o_data; // never leave a usable value after the ack
      wait_cnt <= (i_req && !o_ack) ? wait_cnt + 3'h1 : 3'h0;
    end
  end
endmodule // aod_mem_model
`default_nettype wire

// ---- verification/aod_decoder_properties.sv ----
/* checker for aod_decoder: start, operand, stack and trap timing.
   Assumes one clock domain; bound below to every decoder. */
`timescale 1ns/1ps
`default_nettype none
module aod_checker (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic [4:0] i_gen_a,
  input wire logic i_write_a,
  input wire logic i_write_b,
  input wire logic [2:0] i_operand_len,
  input wire logic i_stack_select,
  input wire logic i_mem_ack,
  input wire logic o_busy,
  input wire logic o_mem_req,
  input wire logic [31:0] o_mem_addr,
  input wire logic o_op_valid,
  input wire logic o_op_index,
  input wire logic [1:0] o_op_kind,
  input wire logic [2:0] o_op_register,
  input wire logic [31:0] o_op_address,
  input wire logic o_sp_update,
  input wire logic o_sp_select,
  input wire logic [31:0] o_sp_value,
  input wire logic o_trap_undefined,
  input wire logic o_done
);
  logic [4:0] gen_a;
  logic wr_a, wr_b, wr;
  logic [2:0] len;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // live inputs may change once taken, so keep the accepted copy
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gen_a <= 5'h00;
      wr_a <= 1'b0;
      wr_b <= 1'b0;
      len <= 3'h0;
    end else if (i_start && !o_busy) begin
      gen_a <= i_gen_a;
      wr_a <= i_write_a;
      wr_b <= i_write_b;
      len <= i_operand_len;
    end
  end
  assign wr = o_op_index ? wr_b : wr_a;
  start_taken_a: assert property (i_start && !o_busy |=> o_busy)
    else $error("start not taken");
  early_op_a: assert property (i_start && !o_busy |=> !o_op_valid ##1 !o_op_valid)
    else $error("operand too early");
  reg_number_a: assert property (o_op_valid && !o_op_index && gen_a[4:3] == 2'h0
    |-> o_op_kind == aod_pkg::KIND_REGISTER && o_op_register == gen_a[2:0]) else $error("bad reg");
  imm_write_a: assert property (o_op_valid && wr |-> o_op_kind != aod_pkg::KIND_IMMEDIATE)
    else $error("written immediate");
  trap_quiet_a: assert property (o_trap_undefined |-> !o_op_valid && !o_done ##[0:1] !o_busy)
    else $error("trap not clean");
  mem_hold_a: assert property (o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr))
    else $error("pointer read dropped");
  push_addr_a: assert property (o_sp_update && wr |-> o_sp_value == o_op_address)
    else $error("push address");
  pop_step_a: assert property (o_sp_update && !wr |-> o_sp_value == o_op_address + {29'h0, len})
    else $error("pop step");
  sp_pick_a: assert property (o_sp_update |-> o_op_valid && o_sp_select == $past(i_stack_select))
    else $error("stack select");
endmodule // aod_checker
bind aod_decoder aod_checker u_chk (.i_clock, .i_rst_n, .i_start, .i_gen_a, .i_write_a,
  .i_write_b, .i_operand_len, .i_stack_select, .i_mem_ack, .o_busy, .o_mem_req, .o_mem_addr,
  .o_op_valid, .o_op_index, .o_op_kind, .o_op_register, .o_op_address, .o_sp_update,
  .o_sp_select, .o_sp_value, .o_trap_undefined, .o_done);
`default_nettype wire

// ---- verification/operand_address_decoder_tb.sv ----
/* bench for aod_decoder: feeds instruction bytes, checks operands.
   Assumes aod_mem_model answers the pointer reads. */
`timescale 1ns/1ps
`default_nettype none
module operand_address_decoder_tb;
  logic i_clock, i_rst_n, i_start, i_two_operands, i_write_a, i_write_b, took, slow;
  logic [4:0] i_gen_a, i_gen_b;
  logic [2:0] i_operand_len;
  logic [1:0] i_implied_count, i_implied_is_disp;
  logic i_byte_valid, o_byte_ready, i_stack_select, i_mem_ack, o_mem_req, o_busy;
  logic [7:0] i_byte;
  logic [255:0] i_gpr;
  logic [31:0] i_frame_pointer, i_stack_pointer_zero, i_stack_pointer_one;
  logic [31:0] i_static_base_pointer, i_program_counter, i_link_table_base;
  logic [31:0] i_mem_data, o_mem_addr, o_op_address, o_op_immediate, o_sp_value, o_implied_value;
  logic o_op_valid, o_op_index, o_sp_update, o_sp_select, o_implied_valid, o_implied_is_disp;
  logic o_trap_undefined, o_done;
  logic [1:0] o_op_kind, kind[2];
  logic [2:0] o_op_register, rnum[2];
  logic [31:0] addr[2], imm[2], spv[2], impl;
  logic impl_d;
  logic [7:0] q[$];
  int error_cnt, comparisons, traps, dones;
  aod_decoder dut (.i_clock, .i_rst_n, .i_start, .i_gen_a, .i_gen_b, .i_two_operands,
    .i_write_a, .i_write_b, .i_operand_len, .i_implied_count, .i_implied_is_disp,
    .i_byte_valid, .i_byte, .o_byte_ready, .i_gpr, .i_frame_pointer, .i_stack_pointer_zero,
    .i_stack_pointer_one, .i_static_base_pointer, .i_program_counter, .i_link_table_base,
    .i_stack_select, .o_mem_req, .o_mem_addr, .i_mem_ack, .i_mem_data, .o_op_valid,
    .o_op_index, .o_op_kind, .o_op_register, .o_op_address, .o_op_immediate, .o_sp_update,
    .o_sp_select, .o_sp_value, .o_implied_valid, .o_implied_is_disp, .o_implied_value,
    .o_trap_undefined, .o_done, .o_busy);
  aod_mem_model mem (.i_clock, .i_rst_n, .i_req(o_mem_req), .i_addr(o_mem_addr),
    .i_slow(slow), .o_ack(i_mem_ack), .o_data(i_mem_data));
  // 20 MHz clock
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  // prefetch queue: a byte stays offered until it has been taken
  always @(negedge i_clock) begin
    if (took) void'(q.pop_front());
    i_byte_valid = q.size() > 0;
    i_byte = (q.size() > 0) ? q[0] : ~i_byte;
    #1 took = i_byte_valid && o_byte_ready;
  end
  // results are read mid-cycle, where the pulses have settled
  always @(negedge i_clock) begin
    if (o_op_valid === 1'b1) begin
      kind[o_op_index] = o_op_kind;
      rnum[o_op_index] = o_op_register;
      addr[o_op_index] = o_op_address;
      imm[o_op_index] = o_op_immediate;
      spv[o_op_index] = o_sp_update ? o_sp_value : 32'h0;
    end
    if (o_implied_valid === 1'b1) {impl_d, impl} = {o_implied_is_disp, o_implied_value};
    if (o_trap_undefined === 1'b1) traps++;
    if (o_done === 1'b1) dones++;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // one instruction: start pulse, then wait for done or trap
  task automatic go(input logic [4:0] ga, input logic [4:0] gb, input logic two,
                    input logic wa, input logic wb);
    int n;
    @(negedge i_clock);
    {i_gen_a, i_gen_b, i_two_operands, i_write_a, i_write_b} = {ga, gb, two, wa, wb};
    {traps, dones} = '0;
    // unknown until captured, so a missing pulse cannot pass a compare
    kind = '{default: 'x};
    rnum = '{default: 'x};
    {impl_d, impl} = 'x;
    addr = '{default: 'x};
    imm = '{default: 'x};
    i_start = 1'b1;
    @(negedge i_clock);
    i_start = 1'b0;
    for (n = 0; n < 300 && traps + dones == 0; n++) @(negedge i_clock);
    if (n == 300) chk(32'h1, 32'h0); // hung instruction
    repeat (2) @(negedge i_clock);
  endtask
  task automatic t_register;
    go(5'h05, 5'h02, 1'b1, 1'b0, 1'b1);
    chk(kind[0], aod_pkg::KIND_REGISTER);
    chk(rnum[0], 3'h5);
    chk(rnum[1], 3'h2);
    chk(dones, 1);
  endtask
  task automatic t_regrel;
    q = '{8'h7f, 8'h05};
    go(5'h0b, 5'h08, 1'b1, 1'b0, 1'b0);
    chk(addr[0], i_gpr[96+:32] - 32'h1);
    chk(addr[1], i_gpr[0+:32] + 32'h5);
    chk(kind[1], aod_pkg::KIND_MEMORY);
  endtask
  task automatic t_lengths;
    q = '{8'hbf, 8'hfe, 8'hc0, 8'h12, 8'h34, 8'h56};
    go(5'h15, 5'h15, 1'b1, 1'b0, 1'b0);
    chk(addr[0], 32'hffff_fffe);
    chk(addr[1], 32'h0012_3456);
  endtask
  task automatic t_space;
    i_stack_select = 1'b1;
    q = '{8'h10, 8'h3c};
    go(5'h18, 5'h19, 1'b1, 1'b0, 1'b0);
    chk(addr[0], i_frame_pointer + 32'h10);
    chk(addr[1], i_stack_pointer_one + 32'h3c);
    i_stack_select = 1'b0;
  endtask
  task automatic t_memrel;
    slow = 1'b1;
    q = '{8'h04, 8'h08, 8'h02, 8'h7e};
    go(5'h10, 5'h16, 1'b1, 1'b0, 1'b0);
    chk(addr[0], ((i_frame_pointer + 32'h4) ^ 32'h5a5a_0000) + 32'h8);
    chk(addr[1], ((i_link_table_base + 32'h8) ^ 32'h5a5a_0000) - 32'h2);
    slow = 1'b0;
  endtask
  task automatic t_imm;
    {i_operand_len, i_implied_count, i_implied_is_disp} = {3'h2, 2'h1, 2'h1};
    q = '{8'h12, 8'h34, 8'h03};
    go(5'h14, 5'h01, 1'b1, 1'b0, 1'b1);
    chk(imm[0], 32'h1234);
    chk(kind[0], aod_pkg::KIND_IMMEDIATE);
    chk(impl, 32'h3);
    chk(impl_d, 1'b1);
    i_implied_count = 2'h0;
  endtask
  task automatic t_tos;
    i_operand_len = 3'h4;
    go(5'h17, 5'h00, 1'b0, 1'b0, 1'b0);
    chk(addr[0], i_stack_pointer_zero);
    chk(spv[0], i_stack_pointer_zero + 32'h4);
    go(5'h17, 5'h00, 1'b0, 1'b1, 1'b0);
    chk(addr[0], i_stack_pointer_zero - 32'h4);
    chk(spv[0], i_stack_pointer_zero - 32'h4);
  endtask
  task automatic t_scaled;
    q = '{8'h4a, 8'h1d, 8'h08};
    go(5'h1e, 5'h1c, 1'b1, 1'b0, 1'b0);
    chk(addr[0], i_gpr[32+:32] + 32'h8 + 32'h4 * i_gpr[64+:32]);
    chk(addr[1], i_gpr[96+:32] + i_gpr[160+:32]);
  endtask
  task automatic t_traps;
    logic [4:0] g[3];
    logic [7:0] b[3];
    g = '{5'h14, 5'h13, 5'h1c};
    b = '{8'h12, 8'h00, 8'ha0};
    i_operand_len = 3'h1;
    for (int k = 0; k < 3; k++) begin
      q.push_back(b[k]);
      go(g[k], 5'h00, 1'b0, k == 0, 1'b0);
      q.delete();
      took = 1'b0;
      chk(traps, 1);
      chk(dones, 0);
    end
  endtask
  // watchdog: the whole run needs far fewer cycles than this
  initial begin
    #(50 * 20000);
    error_cnt++;
    report_and_stop;
  end
  initial begin
    {i_start, i_two_operands, i_write_a, i_write_b, i_stack_select, slow, took} = '0;
    {i_gen_a, i_gen_b, i_implied_count, i_implied_is_disp, i_byte_valid, i_byte} = '0;
    {error_cnt, comparisons, traps, dones} = '0;
    i_operand_len = 3'h1;
    for (int n = 0; n < 8; n++) i_gpr[32*n+:32] = 32'h0000_1000 + 32'h100 * n;
    {i_frame_pointer, i_stack_pointer_zero, i_stack_pointer_one} = {32'h8000, 32'h9000, 32'ha000};
    {i_static_base_pointer, i_program_counter, i_link_table_base} = {32'hb000, 32'hc000, 32'hd000};
    i_rst_n = 1'b0;
    repeat (12) @(negedge i_clock);
    i_rst_n = 1'b1;
    t_register;
    t_regrel;
    t_lengths;
    t_space;
    t_memrel;
    t_imm;
    t_tos;
    t_scaled;
    t_traps;
    report_and_stop;
  end
endmodule // operand_address_decoder_tb
`default_nettype wire
